// >>> rtl/rgseq_map.svh
`ifndef RGSEQ_MAP_SVH
`define RGSEQ_MAP_SVH
// register byte offsets
`define CTRL_OFS 32'h0000_0000
`define RATE_OFS 32'h0000_0004
`define CUT_OFS 32'h0000_0008
`define DACS_OFS 32'h0000_000c
`define STAT_OFS 32'h0000_0010
// control fields
`define CTRL_PWR_RED 0
`define CTRL_PGC 1
`define CTRL_GSF 3:2
`define CTRL_LSF 5:4
`define CTRL_CP 7:6
`define CTRL_PGCW 11:8
`define RATE_DRR 4:0
`define CUT_DATA 6:0
`define CUT_SERVO 14:8
`define DACS_GD 5:0
`define DACS_PTH 12:8
`define DACS_NTH 20:16
// status fields
`define STAT_ST 4:0
`define STAT_GAIN 6:5
`define STAT_TIM 8:7
`define STAT_RGD 9
`define STAT_SERVO 10
`define STAT_PCNT 31:16
// reset values and writable masks
`define CTRL_RST 32'h0000_0000
`define RATE_RST 32'h0000_001f
`define CUT_RST 32'h0000_0000
`define DACS_RST 32'h0000_0000
`define CTRL_WMASK 32'h0000_0fff
`define RATE_WMASK 32'h0000_001f
`define CUT_WMASK 32'h0000_7f7f
`define DACS_WMASK 32'h001f_1f3f
// timing
`define BYTE_BITS 8
`define RGD_DELAY_BYTES 2
`define CLK_PERIOD_NS 8
`define QP_WIDTH_NS 24
`define QP_WIDTH_CYC ((`QP_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GSF_B0 4'h4
`define GSF_B1 4'h5
`define GSF_B2 4'h7
`define GSF_B3 4'h9
`define CP_HIGH_UA 8'hb4
`define CP_STEP_UA 8'h14
`define DRR_MAX 31
`define CNT_SAT 7'h7f
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> rtl/rgseq_pkg.sv
package rgseq_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DELAY = 5'h02,
    ST_GAIN = 5'h04,
    ST_LOCK = 5'h08,
    ST_TRACK = 5'h10
  } acq_state_e;
  typedef enum logic [1:0] {
    GAIN_CONT = 2'h0,
    GAIN_SAMP_HIGH = 2'h1,
    GAIN_SAMP_LOW = 2'h2
  } gain_mode_e;
  typedef enum logic [1:0] {
    TIM_IDLE = 2'h0,
    TIM_ACQ = 2'h1,
    TIM_TRACK = 2'h2
  } timing_mode_e;
  typedef struct packed {
    gain_mode_e gain_mode;
    logic high_gain;
    timing_mode_e timing_mode;
    logic delayed_read_gate;
    logic power_up;
  } loop_ctrl_s;
  typedef struct packed {
    logic [6:0] cutoff;
    logic signed [5:0] group_delay;
    logic [4:0] positive_level_threshold;
    logic [4:0] negative_level_threshold;
    logic [3:0] pgc_gain;
    logic agc_loop_en;
    logic [7:0] cp_ua;
  } dac_ctrl_s;
endpackage

// >>> rtl/read_gate_acquisition_sequencer.sv
// Contract
// [RL1] read gate with power reduction enabled powers up FIR, detector, DD loops
// [RL2] delayed read gate asserts two byte times after read gate
// [RL3] sync-field counting starts at delayed read gate
// [RL4] gain count of 4, 5, 7 or 9 bytes; expiry enters sampled gain
// [RL5] a byte time is eight synthesizer clock periods
// [RL6] lock count of 0 to 3 bytes follows the gain count
// [RL7] high gain lasts for both counts, then low gain
// [RL8] timing loop goes from idle to acquisition at delayed read gate
// [RL9] timing loop tracks once both counts have elapsed
// [RL10] sampled pump current 0/20/40/60 uA at full rate; high gain 180 uA
// [RL11] sampled currents scale from full at max rate to half at min rate
// [RL12] servo mode uses minimum-rate pump currents
// [RL13] programmable gain disables the loop; gain follows a 4-bit code
// [RL14] cutoff code from data register, or servo register when servo gate high
// [RL15] group delay is a six-bit two's complement code
// [RL16] positive and negative thresholds are independent 5-bit codes
// [RL17] level exceeded then peak gives a 24 ns qualified pulse
// [RL18] capture clears at pulse rise; next bit only after one-shot ends
// [RL19] same-polarity pulses qualify; polarity is reported separately
// [RL20] servo gate low selects data read, high selects servo read
// [RL21] one configuration bit picks automatic or programmable gain
// [RL22] read gate low resets delayed gate, counters and timing loop
// [RL23] controller holds read gate through delay and both counts
`timescale 1ns/1ps
`include "rgseq_map.svh"
module read_gate_acquisition_sequencer
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // controller gates
  input wire logic read_gate_in,
  input wire logic servo_gate_select,
  // pulse detector inputs
  input wire logic peak_timing_strobe,
  input wire logic level_pos_in,
  input wire logic level_neg_in,
  // loop and dac control
  output rgseq_pkg::loop_ctrl_s loop_ctrl,
  output rgseq_pkg::dac_ctrl_s dac_ctrl,
  // qualified pulses
  output logic qualified_pulse_out,
  output logic pulse_polarity_out
);
  import rgseq_pkg::*;

  localparam int NSYNC = 5;
  localparam logic [6:0] DLY_CYC = 7'(`RGD_DELAY_BYTES * `BYTE_BITS);
  localparam logic [1:0] QP_CYC = 2'(`QP_WIDTH_CYC);

  // pin synchronisers
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  assign pin_raw = {level_neg_in, level_pos_in, peak_timing_strobe,
                    servo_gate_select, read_gate_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
        end
        else
        begin
          sync1_ff[gi] <= pin_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  wire rg_s = sync2_ff[0];
  wire servo_s = sync2_ff[1];
  wire strobe_s = sync2_ff[2];
  wire lvl_pos_s = sync2_ff[3];
  wire lvl_neg_s = sync2_ff[4];

  // register file
  logic [31:0] ctrl_ff, rate_ff, cut_ff, dacs_ff;
  logic [31:0] nxt_ctrl, nxt_rate, nxt_cut, nxt_dacs;
  logic aw_full_ff, w_full_ff, bvalid_ff, rvalid_ff;
  logic [31:0] aw_addr_ff, w_data_ff, rdata_ff;
  logic [3:0] w_strb_ff;
  logic [1:0] bresp_ff, rresp_ff;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
    merge = (old & ~m) | (data & m);
  endfunction

  assign awready = !aw_full_ff;
  assign wready = !w_full_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = !rvalid_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  wire aw_take = awvalid & !aw_full_ff;
  wire w_take = wvalid & !w_full_ff;
  wire wr_fire = aw_full_ff & w_full_ff & !bvalid_ff;
  wire ar_take = arvalid & !rvalid_ff;

  wire wr_ctrl = wr_fire & (aw_addr_ff == `CTRL_OFS);
  wire wr_rate = wr_fire & (aw_addr_ff == `RATE_OFS);
  wire wr_cut = wr_fire & (aw_addr_ff == `CUT_OFS);
  wire wr_dacs = wr_fire & (aw_addr_ff == `DACS_OFS);
  wire wr_hit = wr_ctrl | wr_rate | wr_cut | wr_dacs;

  assign nxt_ctrl = wr_ctrl ? merge(ctrl_ff, w_data_ff, w_strb_ff, `CTRL_WMASK) : ctrl_ff;
  assign nxt_rate = wr_rate ? merge(rate_ff, w_data_ff, w_strb_ff, `RATE_WMASK) : rate_ff;
  assign nxt_cut = wr_cut ? merge(cut_ff, w_data_ff, w_strb_ff, `CUT_WMASK) : cut_ff;
  assign nxt_dacs = wr_dacs ? merge(dacs_ff, w_data_ff, w_strb_ff, `DACS_WMASK) : dacs_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_ff <= `CTRL_RST;
      rate_ff <= `RATE_RST;
      cut_ff <= `CUT_RST;
      dacs_ff <= `DACS_RST;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      rate_ff <= nxt_rate;
      cut_ff <= nxt_cut;
      dacs_ff <= nxt_dacs;
    end
  end

  // write channels are held until both have arrived
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      aw_addr_ff <= 32'h0;
      w_data_ff <= 32'h0;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
    end
    else
    begin
      aw_full_ff <= aw_take | (aw_full_ff & !wr_fire);
      w_full_ff <= w_take | (w_full_ff & !wr_fire);
      if (aw_take)
        aw_addr_ff <= awaddr;
      if (w_take)
      begin
        w_data_ff <= wdata;
        w_strb_ff <= wstrb;
      end
      bvalid_ff <= wr_fire | (bvalid_ff & !bready);
      if (wr_fire)
        bresp_ff <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  // sequencer state
  acq_state_e state_ff, nxt_state;
  logic [6:0] cnt_ff, nxt_cnt;
  logic [6:0] gsf_cyc_ff, lsf_cyc_ff;
  logic [15:0] pcnt_ff;

  wire [3:0] gain_syncfield_count = (ctrl_ff[`CTRL_GSF] == 2'h0) ? `GSF_B0 :
                                    (ctrl_ff[`CTRL_GSF] == 2'h1) ? `GSF_B1 :
                                    (ctrl_ff[`CTRL_GSF] == 2'h2) ? `GSF_B2 : `GSF_B3;
  wire [3:0] lock_syncfield_count = {2'h0, ctrl_ff[`CTRL_LSF]};

  // read-back mux
  wire [31:0] stat_word = {pcnt_ff, 5'h0, servo_s, loop_ctrl.delayed_read_gate,
                           loop_ctrl.timing_mode, loop_ctrl.gain_mode, state_ff};
  wire rd_ctrl = araddr == `CTRL_OFS;
  wire rd_rate = araddr == `RATE_OFS;
  wire rd_cut = araddr == `CUT_OFS;
  wire rd_dacs = araddr == `DACS_OFS;
  wire rd_stat = araddr == `STAT_OFS;
  wire rd_hit = rd_ctrl | rd_rate | rd_cut | rd_dacs | rd_stat;
  wire [31:0] rd_mux = rd_ctrl ? ctrl_ff : rd_rate ? rate_ff : rd_cut ? cut_ff :
                       rd_dacs ? dacs_ff : rd_stat ? stat_word : 32'h0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= `RESP_OKAY;
    end
    else
    begin
      rvalid_ff <= ar_take | (rvalid_ff & !rready);
      if (ar_take)
      begin
        rdata_ff <= rd_mux;
        rresp_ff <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = 7'(cnt_ff + 7'h1);
    // [RL22] gate drop resets
    if (!rg_s)
    begin
      nxt_state = ST_IDLE;
      nxt_cnt = 7'h0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          nxt_state = ST_DELAY;
          nxt_cnt = 7'h1;
        end
        // [RL2] two byte delay
        ST_DELAY:
          if (cnt_ff == 7'(DLY_CYC - 7'h1))
          begin
            nxt_state = ST_GAIN;
            nxt_cnt = 7'h0;
          end
        // [RL4] gain count expiry
        ST_GAIN:
          if (cnt_ff == 7'(gsf_cyc_ff - 7'h1))
          begin
            nxt_state = (lsf_cyc_ff == 7'h0) ? ST_TRACK : ST_LOCK;
            nxt_cnt = 7'h0;
          end
        // [RL6] lock count follows
        ST_LOCK:
          if (cnt_ff == 7'(lsf_cyc_ff - 7'h1))
          begin
            nxt_state = ST_TRACK;
            nxt_cnt = 7'h0;
          end
        ST_TRACK:
          nxt_cnt = cnt_ff;
        default:
        begin
          nxt_state = ST_IDLE;
          nxt_cnt = 7'h0;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= 7'h0;
      gsf_cyc_ff <= 7'h0;
      lsf_cyc_ff <= 7'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      // [RL5] counts in byte times of eight clocks
      if (state_ff == ST_IDLE)
      begin
        gsf_cyc_ff <= 7'(gain_syncfield_count * `BYTE_BITS);
        lsf_cyc_ff <= 7'(lock_syncfield_count * `BYTE_BITS);
      end
    end
  end

  // loop modes, decoded from the next state so they line up with it
  wire n_rgd = (nxt_state == ST_GAIN) | (nxt_state == ST_LOCK) | (nxt_state == ST_TRACK);
  wire n_acq = (nxt_state == ST_GAIN) | (nxt_state == ST_LOCK);
  loop_ctrl_s nxt_loop;
  always_comb
  begin
    // [RL1] power up on read gate
    nxt_loop.power_up = !ctrl_ff[`CTRL_PWR_RED] | rg_s;
    // [RL3] counting starts at delayed gate
    nxt_loop.delayed_read_gate = n_rgd;
    // [RL8] [RL9] timing loop modes
    nxt_loop.timing_mode = (nxt_state == ST_TRACK) ? TIM_TRACK : n_acq ? TIM_ACQ : TIM_IDLE;
    // [RL7] high gain through both counts
    nxt_loop.high_gain = n_acq;
    nxt_loop.gain_mode = (nxt_state == ST_TRACK) ? GAIN_SAMP_LOW :
                         (nxt_state == ST_LOCK) ? GAIN_SAMP_HIGH : GAIN_CONT;
  end

  // [RL11] [RL12] pump current scales with rate; servo uses minimum
  wire [4:0] drr_eff = servo_s ? 5'h0 : rate_ff[`RATE_DRR];
  wire [7:0] cp_base = 8'(ctrl_ff[`CTRL_CP] * `CP_STEP_UA);
  wire [11:0] cp_num = 12'(12'(cp_base) * (12'(`DRR_MAX) + 12'(drr_eff)));
  wire [7:0] cp_scaled = 8'(cp_num / 12'(2 * `DRR_MAX));
  wire pgc_on = ctrl_ff[`CTRL_PGC];

  dac_ctrl_s nxt_dac;
  always_comb
  begin
    // [RL14] [RL20] cutoff by servo gate
    nxt_dac.cutoff = servo_s ? cut_ff[`CUT_SERVO] : cut_ff[`CUT_DATA];
    // [RL15] signed group delay
    nxt_dac.group_delay = dacs_ff[`DACS_GD];
    // [RL16] independent thresholds
    nxt_dac.positive_level_threshold = dacs_ff[`DACS_PTH];
    nxt_dac.negative_level_threshold = dacs_ff[`DACS_NTH];
    // [RL13] [RL21] programmable gain
    nxt_dac.pgc_gain = pgc_on ? ctrl_ff[`CTRL_PGCW] : 4'h0;
    nxt_dac.agc_loop_en = !pgc_on;
    // [RL10] pump current select
    nxt_dac.cp_ua = pgc_on ? 8'h0 : n_acq ? `CP_HIGH_UA :
                    (nxt_state == ST_TRACK) ? cp_scaled : 8'h0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      loop_ctrl <= '0;
      dac_ctrl <= '0;
    end
    else
    begin
      loop_ctrl <= nxt_loop;
      dac_ctrl <= nxt_dac;
    end
  end

  // pulse qualifier
  logic strobe_d_ff, capture_ff, pol_ff, qp_ff;
  logic [1:0] shot_ff;
  wire peak_rise = strobe_s & !strobe_d_ff;
  // [RL18] accept only with capture clear and one-shot expired
  wire accept = peak_rise & (lvl_pos_s | lvl_neg_s) & !capture_ff & (shot_ff == 2'h0);
  wire [1:0] nxt_shot = capture_ff ? QP_CYC : (shot_ff != 2'h0) ? 2'(shot_ff - 2'h1) : 2'h0;
  assign qualified_pulse_out = qp_ff;
  assign pulse_polarity_out = pol_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      strobe_d_ff <= 1'b0;
      capture_ff <= 1'b0;
      pol_ff <= 1'b0;
      shot_ff <= 2'h0;
      qp_ff <= 1'b0;
      pcnt_ff <= 16'h0;
    end
    else
    begin
      strobe_d_ff <= strobe_s;
      // [RL17] capture then fire one-shot
      capture_ff <= accept;
      shot_ff <= nxt_shot;
      qp_ff <= nxt_shot != 2'h0;
      // [RL19] polarity of every qualified pulse
      if (accept)
        pol_ff <= lvl_pos_s;
      if (capture_ff)
        pcnt_ff <= 16'(pcnt_ff + 16'h1);
    end
  end

  // checking helper: cycles the synchronised gate has been high
  logic [6:0] rg_hi_ff;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rg_hi_ff <= 7'h0;
    else
      rg_hi_ff <= !rg_s ? 7'h0 : (rg_hi_ff == `CNT_SAT) ? rg_hi_ff : 7'(rg_hi_ff + 7'h1);
  end
  wire [6:0] sum_cyc = 7'(DLY_CYC + gsf_cyc_ff + lsf_cyc_ff);

  chk_power_up_gate: // [RL1]
    assert property (@(posedge aclk) disable iff (!aresetn)
      rg_s |=> loop_ctrl.power_up)
    else $error("power up missing during read gate");
  chk_rgd_delay: // [RL2]
    assert property (@(posedge aclk) disable iff (!aresetn)
      loop_ctrl.delayed_read_gate == (rg_hi_ff >= DLY_CYC))
    else $error("delayed read gate not two byte times after gate");
  chk_acq_window: // [RL8]
    assert property (@(posedge aclk) disable iff (!aresetn)
      (rg_hi_ff >= DLY_CYC) && (rg_hi_ff < sum_cyc) |-> loop_ctrl.timing_mode == TIM_ACQ)
    else $error("timing loop not acquiring within sync field");
  chk_track_entry: // [RL9]
    assert property (@(posedge aclk) disable iff (!aresetn)
      (rg_hi_ff == sum_cyc) |-> loop_ctrl.timing_mode == TIM_TRACK
      && loop_ctrl.gain_mode == GAIN_SAMP_LOW)
    else $error("tracking not entered after both counts");
  chk_gain_expiry: // [RL4]
    assert property (@(posedge aclk) disable iff (!aresetn)
      (lsf_cyc_ff != 7'h0) && (rg_hi_ff == 7'(DLY_CYC + gsf_cyc_ff))
      |-> loop_ctrl.gain_mode == GAIN_SAMP_HIGH)
    else $error("sampled gain not entered at gain count expiry");
  chk_gate_drop: // [RL22]
    assert property (@(posedge aclk) disable iff (!aresetn)
      !rg_s |=> state_ff == ST_IDLE && !loop_ctrl.delayed_read_gate)
    else $error("gate drop did not return to idle");
  chk_pulse_width: // [RL17]
    assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(qp_ff) |-> qp_ff[*3] ##1 !qp_ff)
    else $error("qualified pulse not three cycles wide");
  chk_capture_clear: // [RL18]
    assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(qp_ff) |-> !capture_ff ##1 !capture_ff ##1 !capture_ff)
    else $error("capture not cleared during one-shot");
  chk_servo_pump: // [RL12]
    assert property (@(posedge aclk) disable iff (!aresetn)
      servo_s && !pgc_on && $stable(servo_s) && nxt_state == ST_TRACK
      |=> dac_ctrl.cp_ua == 8'($past(cp_base) / 8'h2))
    else $error("servo pump current not at minimum rate");
  chk_pgc_gain: // [RL13]
    assert property (@(posedge aclk) disable iff (!aresetn)
      pgc_on |=> !dac_ctrl.agc_loop_en && dac_ctrl.cp_ua == 8'h0)
    else $error("gain loop active in programmable gain mode");
endmodule

// >>> dv/gate_ctrl_model.sv
`timescale 1ns/1ps
module gate_ctrl_model
(
  // clock
  input wire logic aclk,
  // requests from the bench
  input wire logic start,
  input wire logic [9:0] hold_cyc,
  input wire logic servo_mode,
  // gates towards the sequencer
  output logic read_gate_in,
  output logic servo_gate_select
);
  logic [9:0] left_ff = 10'h000;
  initial
  begin
    read_gate_in = 1'b0;
    servo_gate_select = 1'b0;
  end
  // gate held through delay and both counts
  always @(posedge aclk)
  begin
    if (start)
      left_ff <= hold_cyc;
    else if (left_ff != 10'h000)
      left_ff <= left_ff - 10'h001;
    read_gate_in <= start || (left_ff > 10'h001);
  end
  // high selects servo read, low data read
  always @(posedge aclk)
    servo_gate_select <= servo_mode;
endmodule

// >>> dv/read_gate_acquisition_sequencer_tb_top.sv
`timescale 1ns/1ps
`include "rgseq_map.svh"
module read_gate_acquisition_sequencer_tb_top;
  import rgseq_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic start = 1'b0, servo_mode = 1'b0, strobe = 1'b0, lvl_pos = 1'b0, lvl_neg = 1'b0;
  logic [9:0] hold_cyc = '0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, read_gate_in, servo_gate_select;
  logic [1:0] bresp, rresp;
  logic qpo, pol;
  loop_ctrl_s loop_ctrl;
  dac_ctrl_s dac_ctrl;
  int mismatches = 0;
  int compares = 0;
  int run_len = 0;

  always #4 aclk = ~aclk;

  read_gate_acquisition_sequencer u_dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .read_gate_in(read_gate_in),
    .servo_gate_select(servo_gate_select), .peak_timing_strobe(strobe),
    .level_pos_in(lvl_pos), .level_neg_in(lvl_neg), .loop_ctrl(loop_ctrl),
    .dac_ctrl(dac_ctrl), .qualified_pulse_out(qpo), .pulse_polarity_out(pol));

  gate_ctrl_model u_ctrl (.aclk(aclk), .start(start), .hold_cyc(hold_cyc),
    .servo_mode(servo_mode), .read_gate_in(read_gate_in),
    .servo_gate_select(servo_gate_select));

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic done;
    done = 1'b0;
    // requests change only right after a rising edge, never twice in one step
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40 && !done; n++)
    begin
      @(posedge aclk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        done = 1'b1;
        bready <= 1'b0;
        chk("bresp", 32'(er), 32'(bresp));
      end
    end
    // let the register update reach the registered dac and loop outputs
    @(negedge aclk);
    if (!done)
    begin
      chk("write answer", 32'h1, 32'h0);
      give_verdict();
    end
  endtask

  task automatic axi_read(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40 && !done; n++)
    begin
      @(posedge aclk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        done = 1'b1;
        rready <= 1'b0;
        chk("rdata", ed, rdata);
        chk("rresp", 32'(er), 32'(rresp));
      end
    end
    if (!done)
    begin
      chk("read answer", 32'h1, 32'h0);
      give_verdict();
    end
  endtask

  // one read gate; gs/ls/cps are the control selects, ecp the tracking pump current
  task automatic run_gate(input logic [1:0] gs, input logic [1:0] ls, input logic [1:0] cps,
                          input logic [4:0] data_rate_setting, input logic srv, input logic [7:0] ecp);
    int n, g, l, t_rgd, t_hi, t_trk;
    g = (gs == 2'd0) ? 32 : (gs == 2'd1) ? 40 : (gs == 2'd2) ? 56 : 72;
    l = 8 * int'(ls);
    t_rgd = -1;
    t_hi = -1;
    t_trk = -1;
    axi_write(`CTRL_OFS, {20'h0, 4'h0, cps, ls, gs, 1'b0, 1'b1}, `RESP_OKAY);
    axi_write(`RATE_OFS, {27'h0, data_rate_setting}, `RESP_OKAY);
    servo_mode <= srv;
    repeat (6) @(posedge aclk);
    chk("idle power", 32'h0, 32'(loop_ctrl.power_up));
    hold_cyc <= 10'(26 + g + l);
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    for (n = 0; n < 200 && t_trk < 0; n++)
    begin
      @(negedge aclk);
      if (t_rgd < 0 && loop_ctrl.delayed_read_gate === 1'b1)
      begin
        t_rgd = n;
        chk("acq timing", 32'(TIM_ACQ), 32'(loop_ctrl.timing_mode));
        chk("acq pump", {23'h0, 1'b1, `CP_HIGH_UA}, {loop_ctrl.high_gain, dac_ctrl.cp_ua});
        chk("gate power", 32'h1, 32'(loop_ctrl.power_up));
      end
      if (t_hi < 0 && loop_ctrl.gain_mode === GAIN_SAMP_HIGH)
        t_hi = n;
      if (t_trk < 0 && loop_ctrl.timing_mode === TIM_TRACK)
      begin
        t_trk = n;
        chk("track gain", 32'(GAIN_SAMP_LOW), 32'(loop_ctrl.gain_mode));
        chk("track pump", 32'(ecp), 32'(dac_ctrl.cp_ua));
      end
    end
    chk("gate delay", 32'd18, 32'(t_rgd));
    if (ls != 2'd0)
      chk("gain count", 32'(g), 32'(t_hi - t_rgd));
    chk("acq length", 32'(g + l), 32'(t_trk - t_rgd));
    for (n = 0; n < 200 && loop_ctrl.timing_mode !== TIM_IDLE; n++)
      @(negedge aclk);
    chk("gate drop", 32'(TIM_IDLE), {loop_ctrl.delayed_read_gate, loop_ctrl.timing_mode});
    // a wait that ran out has been counted above; end the run there
    if (t_trk < 0 || loop_ctrl.timing_mode !== TIM_IDLE)
      give_verdict();
  endtask

  task automatic fire(input logic p, input int gap);
    @(posedge aclk);
    lvl_pos <= p;
    lvl_neg <= !p;
    strobe <= 1'b1;
    @(posedge aclk);
    strobe <= 1'b0;
    repeat (gap) @(posedge aclk);
  endtask

  always @(posedge aclk)
  begin
    if (qpo === 1'b1)
      run_len <= run_len + 1;
    else if (run_len != 0)
    begin
      run_len <= 0;
      chk("pulse width", 32'd3, 32'(run_len));
    end
  end

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_read(`CTRL_OFS, `CTRL_RST, `RESP_OKAY);
    axi_read(`RATE_OFS, `RATE_RST, `RESP_OKAY);
    axi_read(`STAT_OFS, 32'h0000_0001, `RESP_OKAY);
    axi_read(32'h0000_0020, 32'h0, `RESP_SLVERR);
    axi_write(`STAT_OFS, 32'hffff_ffff, `RESP_SLVERR);
    axi_write(`DACS_OFS, 32'hffff_ffff, `RESP_OKAY);
    axi_read(`DACS_OFS, `DACS_WMASK, `RESP_OKAY);
    axi_write(`DACS_OFS, 32'h0005_1f20, `RESP_OKAY);
    chk("group delay", 32'hffff_ffe0, 32'(signed'(dac_ctrl.group_delay)));
    chk("thresholds", 32'h3e5, {dac_ctrl.positive_level_threshold, dac_ctrl.negative_level_threshold});
    axi_write(`CUT_OFS, 32'h0000_6a15, `RESP_OKAY);
    repeat (6) @(posedge aclk);
    chk("data cutoff", 32'h15, 32'(dac_ctrl.cutoff));
    servo_mode <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("servo cutoff", 32'h6a, 32'(dac_ctrl.cutoff));
    servo_mode <= 1'b0;
    axi_write(`CTRL_OFS, 32'h0000_0a02, `RESP_OKAY);
    chk("pgc gain", 32'h14, {dac_ctrl.pgc_gain, dac_ctrl.agc_loop_en});
    axi_write(`CTRL_OFS, 32'h0000_0a00, `RESP_OKAY);
    chk("agc gain", 32'h01, {dac_ctrl.pgc_gain, dac_ctrl.agc_loop_en});
    run_gate(2'd0, 2'd3, 2'd3, 5'd31, 1'b0, 8'd60);
    run_gate(2'd1, 2'd0, 2'd2, 5'd0, 1'b0, 8'd20);
    run_gate(2'd2, 2'd1, 2'd1, 5'd31, 1'b1, 8'd10);
    run_gate(2'd3, 2'd2, 2'd3, 5'd10, 1'b0, 8'd39);
    servo_mode <= 1'b0;
    fire(1'b1, 10);
    chk("polarity pos", 32'h1, 32'(pol));
    fire(1'b1, 10);
    fire(1'b0, 0);
    fire(1'b0, 10);
    chk("polarity neg", 32'h0, 32'(pol));
    axi_read(`STAT_OFS, 32'h0003_0001, `RESP_OKAY);
    give_verdict();
  end
endmodule
